// ===== rtl/ebw_params.svh
`ifndef EBW_PARAMS_SVH
`define EBW_PARAMS_SVH
`define EBW_ADDR_WSF 8'h28
`define EBW_ADDR_BSC 8'h29
`define EBW_ADDR_WMC 8'h2b
`define EBW_WSF_RST 16'h7fff
`define EBW_WSF_MASK 16'hffff
`define EBW_BSC_RST 16'hf800
`define EBW_BSC_MASK 16'hf807
`define EBW_WMC_RST 16'h0000
`define EBW_WMC_MASK 16'h0001
`define EBW_MODE_RST 4'h0
`define EBW_BSC_TURN_BIT 11
`define EBW_BSC_HKEEP_BIT 2
`define EBW_BSC_DKEEP_BIT 1
`define EBW_BSC_OFF_BIT 0
`define EBW_WSF_XPA_BIT 15
`endif

// ===== rtl/ebw_pkg.sv
package ebw_pkg;
  typedef enum logic [1:0] {
    EBW_SP_PROG = 2'h0,
    EBW_SP_DATA = 2'h1,
    EBW_SP_IO = 2'h2
  } ebw_space_e;
  typedef enum logic [3:0] {
    EBW_IDLE = 4'h1,
    EBW_EXTRA = 4'h2,
    EBW_WAIT = 4'h4,
    EBW_LAST = 4'h8
  } ebw_state_e;
endpackage

// ===== rtl/ebw_cfg_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ebw_cfg_if;
  logic [15:0] wait_fields;
  logic wait_multiplier_sel;
  logic [3:0] bank_compare_mask;
  logic prog_data_turnaround;
  modport regs (output wait_fields, wait_multiplier_sel, bank_compare_mask, prog_data_turnaround);
  modport seq (input wait_fields, wait_multiplier_sel, bank_compare_mask, prog_data_turnaround);
endinterface
`default_nettype wire

// ===== rtl/ebw_seq.sv
`timescale 1ns/10ps
`default_nettype none
`include "ebw_params.svh"
module ebw_seq (
  input wire logic clk_i,
  input wire logic reset_n_i,
  ebw_cfg_if.seq cfg,
  input wire logic acc_req_i,
  input wire ebw_pkg::ebw_space_e acc_space_i,
  input wire logic acc_write_i,
  input wire logic [15:0] acc_addr_i,
  input wire logic ready_s_i,
  output logic acc_done_o,
  output logic busy_o,
  output logic strobe_o
);
  import ebw_pkg::*;
  ebw_state_e st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [1:0] extra_r, extra_nxt;
  logic [3:0] pend_wait_r, pend_wait_nxt;
  logic [3:0] last_bank_r, last_bank_nxt;
  ebw_space_e last_sp_r, last_sp_nxt;
  logic last_rd_r, last_rd_nxt;
  logic have_last_r, have_last_nxt;
  logic [2:0] base;
  logic [3:0] waits;
  logic bank_chg, cross_dp, turn;
  logic [1:0] extra;

  function automatic logic [2:0] fld(input logic [15:0] w, input int idx);
    fld = w[idx*3 +: 3];
  endfunction

  // range select for the access being started
  always_comb begin
    base = fld(cfg.wait_fields, 4);
    unique case (acc_space_i)
      EBW_SP_PROG: begin
        if (cfg.wait_fields[`EBW_WSF_XPA_BIT] || !acc_addr_i[15]) begin
          base = fld(cfg.wait_fields, 0);
        end else begin
          base = fld(cfg.wait_fields, 1);
        end
      end
      EBW_SP_DATA: base = acc_addr_i[15] ? fld(cfg.wait_fields, 3) : fld(cfg.wait_fields, 2);
      EBW_SP_IO: base = fld(cfg.wait_fields, 4);
      default: base = fld(cfg.wait_fields, 4);
    endcase
    waits = cfg.wait_multiplier_sel ? {base, 1'b0} : {1'b0, base};
    bank_chg = have_last_r && (last_sp_r == acc_space_i) && (acc_space_i != EBW_SP_IO) &&
               (((last_bank_r ^ acc_addr_i[15:12]) & cfg.bank_compare_mask) != 4'h0);
    cross_dp = have_last_r && (last_sp_r == EBW_SP_DATA) && (acc_space_i == EBW_SP_PROG);
    turn = cfg.prog_data_turnaround && have_last_r && last_rd_r && !acc_write_i &&
           (((last_sp_r == EBW_SP_DATA) && (acc_space_i == EBW_SP_PROG)) ||
            ((last_sp_r == EBW_SP_PROG) && (acc_space_i == EBW_SP_DATA)));
    extra = {1'b0, bank_chg || cross_dp} + {1'b0, turn};
  end

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    extra_nxt = extra_r;
    pend_wait_nxt = pend_wait_r;
    last_bank_nxt = last_bank_r;
    last_sp_nxt = last_sp_r;
    last_rd_nxt = last_rd_r;
    have_last_nxt = have_last_r;
    acc_done_o = 1'b0;
    unique case (st_r)
      EBW_IDLE: begin
        if (acc_req_i) begin
          last_bank_nxt = acc_addr_i[15:12];
          last_sp_nxt = acc_space_i;
          last_rd_nxt = !acc_write_i;
          have_last_nxt = 1'b1;
          pend_wait_nxt = waits;
          extra_nxt = extra;
          cnt_nxt = waits;
          if (extra != 2'h0) begin
            st_nxt = EBW_EXTRA;
          end else if (waits != 4'h0) begin
            st_nxt = EBW_WAIT;
          end else begin
            st_nxt = EBW_LAST;
          end
        end
      end
      EBW_EXTRA: begin
        extra_nxt = extra_r - 2'h1;
        if (extra_r == 2'h1) begin
          st_nxt = (pend_wait_r != 4'h0) ? EBW_WAIT : EBW_LAST;
        end
      end
      EBW_WAIT: begin
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r == 4'h1) begin
          st_nxt = EBW_LAST;
        end
      end
      EBW_LAST: begin
        // ready low stretches past the programmed count
        if (ready_s_i) begin
          acc_done_o = 1'b1;
          st_nxt = EBW_IDLE;
        end
      end
      default: st_nxt = EBW_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= EBW_IDLE;
      cnt_r <= 4'h0;
      extra_r <= 2'h0;
      pend_wait_r <= 4'h0;
      last_bank_r <= 4'h0;
      last_sp_r <= EBW_SP_PROG;
      last_rd_r <= 1'b0;
      have_last_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      extra_r <= extra_nxt;
      pend_wait_r <= pend_wait_nxt;
      last_bank_r <= last_bank_nxt;
      last_sp_r <= last_sp_nxt;
      last_rd_r <= last_rd_nxt;
      have_last_r <= have_last_nxt;
    end
  end

  assign busy_o = (st_r != EBW_IDLE);
  // bank/turn cycles precede the strobe so the address settles first
  assign strobe_o = (st_r == EBW_WAIT) || (st_r == EBW_LAST);
endmodule
`default_nettype wire

// ===== rtl/ebw_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "ebw_params.svh"
module ebw_ctrl (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic mmr_wr_i,
  input wire logic [7:0] mmr_addr_i,
  input wire logic [15:0] mmr_wdata_i,
  output logic [15:0] mmr_rdata_o,
  input wire logic acc_req_i,
  input wire ebw_pkg::ebw_space_e acc_space_i,
  input wire logic acc_write_i,
  input wire logic [15:0] acc_addr_i,
  input wire logic [15:0] acc_wdata_i,
  output logic acc_done_o,
  output logic acc_busy_o,
  input wire logic ready_i,
  input wire logic mode_wr_i,
  input wire logic [3:0] mode_wdata_i,
  output logic [3:0] mode_bits_o,
  output logic [15:0] ext_addr_o,
  output logic [15:0] ext_data_o,
  output logic ext_data_oe_o,
  input wire logic [15:0] ext_data_i,
  output logic mem_strobe_n_o,
  output logic rw_n_o,
  output logic io_strobe_n_o,
  input wire logic [7:0] host_data_i,
  input wire logic host_data_driven_i,
  output logic [7:0] host_keep_o,
  output logic host_keep_oe_o,
  output logic data_keep_oe_o
);
  import ebw_pkg::*;
  ebw_cfg_if cfg ();
  logic [15:0] wsf_r, wsf_nxt;
  logic [15:0] bsc_r, bsc_nxt;
  logic [15:0] wmc_r, wmc_nxt;
  logic [3:0] mode_r, mode_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic [15:0] wd_r, wd_nxt;
  logic [15:0] dkeep_r, dkeep_nxt;
  logic [7:0] hkeep_r, hkeep_nxt;
  logic rw_n_r, rw_n_nxt;
  logic io_r, io_nxt;
  logic off_r, off_nxt;
  logic rdy_m_r, rdy_s_r;
  logic [15:0] rdata_r, rdata_nxt;
  logic [15:0] ed_m_r, ed_s_r;
  logic [7:0] hd_m_r, hd_s_r;
  logic hdrv_m_r, hdrv_s_r;
  logic [1:0] rd_d_r;
  logic seq_strobe, seq_busy, seq_done, start;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  function automatic logic [15:0] rd_mux(input logic [7:0] a, input logic [15:0] w, input logic [15:0] b,
                                         input logic [15:0] m);
    rd_mux = 16'h0000;
    if (hit(a, `EBW_ADDR_WSF)) begin
      rd_mux = w;
    end else if (hit(a, `EBW_ADDR_BSC)) begin
      rd_mux = b;
    end else if (hit(a, `EBW_ADDR_WMC)) begin
      rd_mux = m;
    end
  endfunction

  assign cfg.wait_fields = wsf_r;
  assign cfg.wait_multiplier_sel = wmc_r[0];
  assign cfg.bank_compare_mask = bsc_r[15:12];
  assign cfg.prog_data_turnaround = bsc_r[`EBW_BSC_TURN_BIT];

  // accesses are held off while the bus is switched off
  assign start = acc_req_i && !off_r;

  ebw_seq u_seq (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .cfg(cfg),
    .acc_req_i(start),
    .acc_space_i(acc_space_i),
    .acc_write_i(acc_write_i),
    .acc_addr_i(acc_addr_i),
    .ready_s_i(rdy_s_r),
    .acc_done_o(seq_done),
    .busy_o(seq_busy),
    .strobe_o(seq_strobe)
  );

  always_comb begin
    wsf_nxt = wsf_r;
    bsc_nxt = bsc_r;
    wmc_nxt = wmc_r;
    mode_nxt = mode_r;
    if (mmr_wr_i && hit(mmr_addr_i, `EBW_ADDR_WSF)) begin
      wsf_nxt = mmr_wdata_i & `EBW_WSF_MASK;
    end
    if (mmr_wr_i && hit(mmr_addr_i, `EBW_ADDR_BSC)) begin
      bsc_nxt = mmr_wdata_i & `EBW_BSC_MASK;
    end
    if (mmr_wr_i && hit(mmr_addr_i, `EBW_ADDR_WMC)) begin
      wmc_nxt = mmr_wdata_i & `EBW_WMC_MASK;
    end
    if (mode_wr_i && !off_r) begin
      mode_nxt = mode_wdata_i;
    end
    rdata_nxt = rd_mux(mmr_addr_i, wsf_r, bsc_r, wmc_r);
  end

  // off takes effect only once no cycle is in progress
  always_comb begin
    off_nxt = bsc_r[`EBW_BSC_OFF_BIT] && !seq_busy && !start;
    if (!bsc_r[`EBW_BSC_OFF_BIT]) begin
      off_nxt = 1'b0;
    end else if (off_r) begin
      off_nxt = 1'b1;
    end
    addr_nxt = addr_r;
    wd_nxt = wd_r;
    rw_n_nxt = rw_n_r;
    io_nxt = io_r;
    if (start && !seq_busy) begin
      addr_nxt = acc_addr_i;
      wd_nxt = acc_wdata_i;
      rw_n_nxt = !acc_write_i;
      io_nxt = (acc_space_i == EBW_SP_IO);
    end else if (off_r) begin
      addr_nxt = 16'h0000;
      rw_n_nxt = 1'b1;
      io_nxt = 1'b0;
    end
    dkeep_nxt = dkeep_r;
    if (seq_strobe && !rw_n_r) begin
      dkeep_nxt = wd_r;
    end else if (rd_d_r[1]) begin
      // read data reaches the keeper two cycles late through the pin synchroniser
      dkeep_nxt = ed_s_r;
    end
    hkeep_nxt = hdrv_s_r ? hd_s_r : hkeep_r;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wsf_r <= `EBW_WSF_RST;
      bsc_r <= `EBW_BSC_RST;
      wmc_r <= `EBW_WMC_RST;
      mode_r <= `EBW_MODE_RST;
      addr_r <= 16'h0000;
      wd_r <= 16'h0000;
      rw_n_r <= 1'b1;
      io_r <= 1'b0;
      off_r <= 1'b0;
      dkeep_r <= 16'h0000;
      hkeep_r <= 8'h00;
      rdata_r <= 16'h0000;
    end else begin
      wsf_r <= wsf_nxt;
      bsc_r <= bsc_nxt;
      wmc_r <= wmc_nxt;
      mode_r <= mode_nxt;
      addr_r <= addr_nxt;
      wd_r <= wd_nxt;
      rw_n_r <= rw_n_nxt;
      io_r <= io_nxt;
      off_r <= off_nxt;
      dkeep_r <= dkeep_nxt;
      hkeep_r <= hkeep_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // pins from outside the clock domain pass two flip-flops before use, except host_data_driven_i, which also gates the keeper enable raw
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdy_m_r <= 1'b1;
      rdy_s_r <= 1'b1;
      ed_m_r <= 16'h0000;
      ed_s_r <= 16'h0000;
      hd_m_r <= 8'h00;
      hd_s_r <= 8'h00;
      hdrv_m_r <= 1'b0;
      hdrv_s_r <= 1'b0;
      rd_d_r <= 2'h0;
    end else begin
      rdy_m_r <= ready_i;
      rdy_s_r <= rdy_m_r;
      ed_m_r <= ext_data_i;
      ed_s_r <= ed_m_r;
      hd_m_r <= host_data_i;
      hd_s_r <= hd_m_r;
      hdrv_m_r <= host_data_driven_i;
      hdrv_s_r <= hdrv_m_r;
      rd_d_r <= {rd_d_r[0], seq_strobe && rw_n_r};
    end
  end

  assign mmr_rdata_o = rdata_r;
  assign mode_bits_o = mode_r;
  assign acc_done_o = seq_done;
  assign acc_busy_o = seq_busy || off_r;
  assign ext_addr_o = addr_r;
  assign rw_n_o = rw_n_r;
  assign mem_strobe_n_o = !(seq_strobe && !io_r);
  assign io_strobe_n_o = !(seq_strobe && io_r);
  assign ext_data_oe_o = seq_strobe && !rw_n_r;
  assign ext_data_o = (seq_strobe && !rw_n_r) ? wd_r : dkeep_r;
  // keeper drives the last level only while no one else drives
  assign data_keep_oe_o = !seq_strobe && bsc_r[`EBW_BSC_DKEEP_BIT];
  assign host_keep_o = hkeep_r;
  // enable stays on the raw pin: a synchronised one would fight the host for two cycles
  assign host_keep_oe_o = bsc_r[`EBW_BSC_HKEEP_BIT] && !host_data_driven_i;
endmodule
`default_nettype wire

// ===== tb/ebw_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module ebw_mem_model (
  input wire logic clk_i,
  input wire logic strobe_n_i,
  input wire logic [15:0] addr_i,
  output logic [15:0] data_o,
  output logic ready_o
);
  int stall = 0;
  int cnt = 0;
  initial begin
    data_o = 16'h0;
    ready_o = 1'b1;
  end
  // a released bus toggles so a stale value is never mistaken for read data
  always @(posedge clk_i) begin
    cnt <= strobe_n_i ? 0 : cnt + 1;
    ready_o <= strobe_n_i || cnt >= stall;
    data_o <= strobe_n_i ? ~data_o : addr_i ^ 16'h5a5a;
  end
endmodule
`default_nettype wire

// ===== tb/ebw_ctrl_checker.sv
`timescale 1ns/10ps
`default_nettype none
module ebw_ctrl_checker (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] mmr_addr_i,
  input wire logic [15:0] mmr_rdata_o,
  input wire logic acc_req_i,
  input wire logic acc_busy_o,
  input wire logic acc_done_o,
  input wire logic mode_wr_i,
  input wire logic [3:0] mode_bits_o,
  input wire logic ext_data_oe_o,
  input wire logic data_keep_oe_o,
  input wire logic mem_strobe_n_o,
  input wire logic io_strobe_n_o,
  input wire logic host_data_driven_i,
  input wire logic host_keep_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  wait_multiplier_config_resv_a: assert property ($past(mmr_addr_i) == 8'h2b |-> mmr_rdata_o[15:1] == 15'h0)
    else $error("multiplier reserved bits nonzero");
  bank_switch_control_resv_a: assert property ($past(mmr_addr_i) == 8'h29 |-> mmr_rdata_o[10:3] == 8'h0)
    else $error("bank control reserved bits nonzero");
  strobe_excl_a: assert property (!io_strobe_n_o |-> mem_strobe_n_o)
    else $error("port and memory strobes both low");
  done_pulse_a: assert property (acc_done_o |-> !(mem_strobe_n_o && io_strobe_n_o) ##1 !acc_done_o)
    else $error("done without strobe or longer than one cycle");
  take_bound_a: assert property (acc_req_i && !acc_busy_o |-> ##[1:60] acc_done_o)
    else $error("access never completed");
  mode_lock_a: assert property (!$past(mode_wr_i) |-> $stable(mode_bits_o))
    else $error("mode bits changed without a write");
  keep_excl_a: assert property (ext_data_oe_o |-> !data_keep_oe_o)
    else $error("data keeper fights the driver");
  host_keep_a: assert property (host_data_driven_i |-> !host_keep_oe_o)
    else $error("host keeper fights the host");
  cover property (acc_req_i && !acc_busy_o);
  cover property (data_keep_oe_o && host_keep_oe_o);
  cover property (acc_busy_o && mem_strobe_n_o && io_strobe_n_o);
endmodule
bind ebw_ctrl ebw_ctrl_checker i_chk (.clk_i, .reset_n_i, .mmr_addr_i, .mmr_rdata_o, .acc_req_i, .acc_busy_o,
  .acc_done_o, .mode_wr_i, .mode_bits_o, .ext_data_oe_o, .data_keep_oe_o, .mem_strobe_n_o, .io_strobe_n_o,
  .host_data_driven_i, .host_keep_oe_o);
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ebw_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic mmr_wr_i = 1'b0;
  logic [7:0] mmr_addr_i = 8'h0;
  logic [15:0] mmr_wdata_i = 16'h0;
  logic acc_req_i = 1'b0;
  ebw_space_e acc_space_i = EBW_SP_DATA;
  logic acc_write_i = 1'b0;
  logic [15:0] acc_addr_i = 16'h0;
  logic [15:0] acc_wdata_i = 16'h0;
  logic mode_wr_i = 1'b0;
  logic [3:0] mode_wdata_i = 4'h0;
  logic host_data_driven_i = 1'b0;
  logic [7:0] hnoise = 8'h3c;
  logic [15:0] mmr_rdata_o, ext_addr_o, ext_data_o, ext_data_i, mdl_data;
  logic [7:0] host_data_i, host_keep_o;
  logic [3:0] mode_bits_o;
  logic acc_done_o, acc_busy_o, ready_i, ext_data_oe_o, mem_strobe_n_o, rw_n_o, io_strobe_n_o;
  logic host_keep_oe_o, data_keep_oe_o;
  int failures = 0;
  int n_checks = 0;
  int last_n;
  ebw_ctrl i_dut (.clk_i, .reset_n_i, .mmr_wr_i, .mmr_addr_i, .mmr_wdata_i, .mmr_rdata_o, .acc_req_i, .acc_space_i,
    .acc_write_i, .acc_addr_i, .acc_wdata_i, .acc_done_o, .acc_busy_o, .ready_i, .mode_wr_i, .mode_wdata_i,
    .mode_bits_o, .ext_addr_o, .ext_data_o, .ext_data_oe_o, .ext_data_i, .mem_strobe_n_o, .rw_n_o, .io_strobe_n_o,
    .host_data_i, .host_data_driven_i, .host_keep_o, .host_keep_oe_o, .data_keep_oe_o);
  ebw_mem_model i_mdl (.clk_i, .strobe_n_i(mem_strobe_n_o & io_strobe_n_o), .addr_i(ext_addr_o),
    .data_o(mdl_data), .ready_o(ready_i));
  assign ext_data_i = (ext_data_oe_o || data_keep_oe_o) ? ext_data_o : mdl_data;
  // undriven host bus wanders unless the keeper holds it
  assign host_data_i = host_data_driven_i ? 8'ha5 : (host_keep_oe_o ? host_keep_o : hnoise);
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) hnoise <= ~hnoise;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    mmr_wr_i <= 1'b1;
    mmr_addr_i <= a;
    mmr_wdata_i <= d;
    @(posedge clk_i);
    mmr_wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    mmr_addr_i <= a;
    @(posedge clk_i);
    @(negedge clk_i);
    chk(mmr_rdata_o, e);
    @(posedge clk_i);
  endtask
  task automatic md(input logic [3:0] v);
    mode_wr_i <= 1'b1;
    mode_wdata_i <= v;
    @(posedge clk_i);
    mode_wr_i <= 1'b0;
    @(negedge clk_i);
  endtask
  // port space writes, memory reads; exp of zero skips the latency compare
  task automatic acc(input ebw_space_e s, input logic [15:0] a, input int exp);
    logic [1:0] strb;
    strb = 2'b00;
    acc_req_i <= 1'b1;
    acc_space_i <= s;
    acc_addr_i <= a;
    acc_wdata_i <= ~a;
    acc_write_i <= (s == EBW_SP_IO);
    @(posedge clk_i);
    acc_req_i <= 1'b0;
    last_n = 0;
    do begin
      @(negedge clk_i);
      last_n++;
      strb = strb | {!io_strobe_n_o, !mem_strobe_n_o};
    end while (acc_done_o !== 1'b1 && last_n < 99);
    if (exp > 0) chk(16'(last_n), 16'(exp));
    chk(16'({acc_done_o, rw_n_o, strb}), (s == EBW_SP_IO) ? 16'ha : 16'hd);
    chk(ext_addr_o, a);
    @(posedge clk_i);
  endtask
  task automatic t_reset();
    rd(8'h28, 16'h7fff);
    rd(8'h29, 16'hf800);
    rd(8'h2b, 16'h0000);
    rd(8'h2a, 16'h0000);
    acc(EBW_SP_IO, 16'h0040, 8);
    wr(8'h2b, 16'hffff);
    rd(8'h2b, 16'h0001);
    wr(8'h29, 16'hfffe);
    rd(8'h29, 16'hf806);
    $display("reset test finished");
  endtask
  task automatic t_waits();
    wr(8'h2b, 16'h0000);
    wr(8'h29, 16'hf000);
    wr(8'h28, 16'h14e5);
    acc(EBW_SP_DATA, 16'h0100, 4);
    acc(EBW_SP_DATA, 16'h0200, 4);
    acc(EBW_SP_DATA, 16'h9000, 4);
    acc(EBW_SP_PROG, 16'h9000, 6);
    acc(EBW_SP_PROG, 16'h1000, 7);
    acc(EBW_SP_DATA, 16'h0000, 4);
    wr(8'h29, 16'hf800);
    acc(EBW_SP_PROG, 16'h1000, 8);
    acc(EBW_SP_DATA, 16'h0000, 5);
    wr(8'h2b, 16'h0001);
    acc(EBW_SP_DATA, 16'h0010, 7);
    wr(8'h29, 16'h0000);
    acc(EBW_SP_DATA, 16'hf000, 5);
    wr(8'h29, 16'h8000);
    acc(EBW_SP_DATA, 16'h7000, 8);
    wr(8'h28, 16'h7fff);
    acc(EBW_SP_DATA, 16'h7010, 15);
    i_mdl.stall = 20;
    acc(EBW_SP_DATA, 16'h7020, 0);
    chk(16'(last_n > 20), 16'h1);
    i_mdl.stall = 0;
    $display("wait test finished");
  endtask
  task automatic t_keep();
    wr(8'h29, 16'h0006);
    host_data_driven_i <= 1'b1;
    @(posedge clk_i);
    host_data_driven_i <= 1'b0;
    acc(EBW_SP_IO, 16'hedcb, 0);
    repeat (3) @(negedge clk_i);
    chk(16'({host_keep_oe_o, host_keep_o}), 16'h1a5);
    chk(16'(data_keep_oe_o), 16'h1);
    chk(ext_data_o, 16'h1234);
    @(posedge clk_i);
    acc(EBW_SP_DATA, 16'h0300, 0);
    repeat (3) @(negedge clk_i);
    chk(ext_data_o, 16'h595a);
    @(posedge clk_i);
    wr(8'h29, 16'h0000);
    @(negedge clk_i);
    chk(16'({host_keep_oe_o, data_keep_oe_o}), 16'h0);
    @(posedge clk_i);
    $display("keeper test finished");
  endtask
  task automatic t_off();
    md(4'h5);
    @(posedge clk_i);
    wr(8'h29, 16'h0001);
    repeat (3) @(negedge clk_i);
    chk(16'({acc_busy_o, mem_strobe_n_o, io_strobe_n_o}), 16'h7);
    chk(ext_addr_o, 16'h0000);
    @(posedge clk_i);
    acc_req_i <= 1'b1;
    @(posedge clk_i);
    acc_req_i <= 1'b0;
    @(negedge clk_i);
    chk(16'({acc_busy_o, mem_strobe_n_o, io_strobe_n_o}), 16'h7);
    @(posedge clk_i);
    md(4'ha);
    chk(16'(mode_bits_o), 16'h5);
    @(posedge clk_i);
    wr(8'h29, 16'h0000);
    md(4'ha);
    chk(16'({acc_busy_o, mode_bits_o}), 16'ha);
    @(posedge clk_i);
    $display("bus off test finished");
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #20000;
    failures++;
    complete_run();
  end
  initial begin
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_waits();
    t_keep();
    t_off();
    complete_run();
  end
endmodule
`default_nettype wire
